// File: logic/hse_pkg.sv
`default_nettype none
package hse_pkg;
  // Register map
  localparam logic [7:0] ADDR_EN2 = 8'h1e;
  localparam logic [7:0] ADDR_RSVD = 8'h1f;
  localparam logic [7:0] ADDR_CLK_KEY = 8'h66;
  localparam logic [7:0] EN2_RESET = 8'h01;
  localparam logic [7:0] CLK_KEY_RESET = 8'h00;
  localparam logic [7:0] RSVD_VALUE = 8'h00;
  localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
  localparam logic [7:0] CLK_KEY_UNLOCK = 8'hf1;
  // Field positions in the second enable register
  localparam int EN2_LEFT = 7;
  localparam int EN2_RIGHT = 6;
  localparam int EN2_SLEW_DIS = 5;
  localparam int EN2_RSVD4 = 4;
  localparam int EN2_FAST = 3;
  localparam int EN2_THR = 2;
  localparam int EN2_MODE_HI = 1;
  localparam int EN2_MODE_LO = 0;
  // Automatic mode field encodings
  localparam logic [1:0] MODE_MANUAL = 2'h0;
  localparam logic [1:0] MODE_GATED = 2'h1;
  localparam logic [1:0] MODE_FORCED = 2'h2;
  // Serial bus device address, arbitrary value
  localparam logic [6:0] DEV_ADDR = 7'h2a;
  // Timing
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned POLL_SLOW_S = 2;
  localparam int unsigned POLL_FAST_MS = 333;
  localparam int unsigned POLL_SLOW_CYC_DEF = POLL_SLOW_S * CLK_MHZ * 1000000;
  localparam int unsigned POLL_FAST_CYC_DEF = POLL_FAST_MS * CLK_MHZ * 1000;
  localparam int unsigned SLEW_STEP_US = 10;
  localparam int unsigned SLEW_STEP_CYC = SLEW_STEP_US * CLK_MHZ;
  localparam logic [11:0] SLEW_LAST = 12'(SLEW_STEP_CYC - 1);
  // Volume
  localparam int VOL_W = 6;
  localparam logic [VOL_W-1:0] VOL_MIN = 6'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
  } hse_i2c_state_t;
endpackage
`default_nettype wire

// File: logic/hse_regbus_if.sv
`default_nettype none
interface hse_regbus_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr_stb;
  modport ctl (output addr, output wdata, output wr_stb, input rdata);
  modport regs (input addr, input wdata, input wr_stb, output rdata);
endinterface
`default_nettype wire

// File: logic/hse_i2c_slave.sv
`default_nettype none
module hse_i2c_slave (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  hse_regbus_if.ctl bus
);
  import hse_pkg::*;
  hse_i2c_state_t state_reg;
  logic scl_prev_reg, sda_prev_reg, rw_reg, nack_reg, wr_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg, ptr_reg, wdata_reg;
  logic scl_rise, scl_fall, start_seen, stop_seen, byte_done;

  // Line history for edges and bus conditions
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_in;
      sda_prev_reg <= sda_in;
    end
  end
  assign scl_rise = scl_in & ~scl_prev_reg;
  assign scl_fall = ~scl_in & scl_prev_reg;
  assign start_seen = scl_in & scl_prev_reg & sda_prev_reg & ~sda_in;
  assign stop_seen = scl_in & scl_prev_reg & ~sda_prev_reg & sda_in;
  assign byte_done = scl_fall && cnt_reg == BITS_PER_BYTE;

  // Transfer sequencer: address, pointer, then data bytes with auto increment
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
    end else if (start_seen) begin
      state_reg <= ST_ADDR;
      cnt_reg <= 4'h0;
    end else if (stop_seen) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise) begin
            sh_reg <= {sh_reg[6:0], sda_in};
            cnt_reg <= cnt_reg + 4'h1;
          end
          if (byte_done) begin
            if (state_reg == ST_ADDR) begin
              rw_reg <= sh_reg[0];
              state_reg <= (sh_reg[7:1] == DEV_ADDR) ? ST_ADDR_ACK : ST_IDLE;
            end else if (state_reg == ST_PTR) begin
              ptr_reg <= sh_reg;
              state_reg <= ST_PTR_ACK;
            end else begin
              state_reg <= ST_WACK;
            end
          end
        end
        ST_ADDR_ACK, ST_PTR_ACK, ST_WACK: begin
          if (scl_fall) begin
            cnt_reg <= 4'h0;
            if (state_reg == ST_ADDR_ACK && rw_reg) begin
              sh_reg <= bus.rdata;
              state_reg <= ST_RDATA;
            end else begin
              state_reg <= (state_reg == ST_ADDR_ACK) ? ST_PTR : ST_WDATA;
            end
            if (state_reg == ST_WACK) begin
              ptr_reg <= ptr_reg + 8'h01;
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall && cnt_reg == 4'h7) begin
            state_reg <= ST_RACK;
            ptr_reg <= ptr_reg + 8'h01;
          end else if (scl_fall) begin
            sh_reg <= {sh_reg[6:0], 1'b0};
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            nack_reg <= sda_in;
          end
          if (scl_fall && nack_reg) begin
            state_reg <= ST_IDLE;
          end else if (scl_fall) begin
            sh_reg <= bus.rdata;
            cnt_reg <= 4'h0;
            state_reg <= ST_RDATA;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // One-cycle write strobe with the received byte
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= 1'b0;
      wdata_reg <= 8'h00;
    end else begin
      wr_reg <= state_reg == ST_WDATA && byte_done && !start_seen && !stop_seen;
      if (state_reg == ST_WDATA && byte_done) begin
        wdata_reg <= sh_reg;
      end
    end
  end

  // Open-drain drive: pull low for acknowledge and for zero data bits
  assign sda_oe = state_reg == ST_ADDR_ACK || state_reg == ST_PTR_ACK || state_reg == ST_WACK ||
    (state_reg == ST_RDATA && !sh_reg[7]);
  assign bus.addr = ptr_reg;
  assign bus.wdata = wdata_reg;
  assign bus.wr_stb = wr_reg;
endmodule
`default_nettype wire

// File: logic/hse_poll_timer.sv
`default_nettype none
module hse_poll_timer #(
  parameter int unsigned SLOW_CYC = hse_pkg::POLL_SLOW_CYC_DEF,
  parameter int unsigned FAST_CYC = hse_pkg::POLL_FAST_CYC_DEF
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic fast_sel,
  input wire logic switch_ok,
  input wire logic switch_closed,
  output logic poll_req
);
  import hse_pkg::*;
  logic [31:0] cnt_reg;
  logic [31:0] last;
  logic sw_prev_reg;
  logic wrap;

  // Interval end depends on the polling speed bit
  assign last = fast_sel ? FAST_CYC - 1 : SLOW_CYC - 1;
  assign wrap = cnt_reg >= last;

  // Interval counter runs only while the mechanical switch is unusable
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 32'h0;
    end else if (switch_ok || wrap) begin
      cnt_reg <= 32'h0;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
    end
  end

  // Poll pulse: switch closing at once, or interval tick otherwise
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sw_prev_reg <= 1'b0;
      poll_req <= 1'b0;
    end else begin
      sw_prev_reg <= switch_closed;
      poll_req <= switch_ok ? switch_closed & ~sw_prev_reg : wrap;
    end
  end

  poll_tick_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!switch_ok && cnt_reg == last) |=> poll_req)
    else $error("poll tick missing at interval end");
  poll_sw_a: assert property (@(posedge clock) disable iff (!rst_n)
    (switch_ok && $past(switch_ok) && !$past(switch_closed) && switch_closed) |=> poll_req)
    else $error("switch insertion not reported at once");
endmodule
`default_nettype wire

// File: logic/hse_regs_top.sv
`default_nettype none
// Overview of operation
// - Bit 7 enables the left headphone channel; resets zero.
// - Bit 6 enables the right headphone channel; resets zero.
// - Channel bits turn read-only status in automatic modes 01 and 10.
// - Bit 5 zero steps volume through intermediate values; one disables stepping.
// - With stepping, volume ramps up from minimum at turn-on, down at turn-off.
// - Bit 3 picks polling: zero every 2 s, one every 333 ms.
// - Polling applies only without a working detect switch; else insertion detection is immediate.
// - Bit 2 selects class-G switching threshold: zero low, one high.
// - Bits 1-0 form the mode field, reset 01; automatic makes enables read-only.
// - Mode 00: software owns enables, registers writable, shutdown and sleep ignored.
// - Mode 01: detection drives enables while shutdown one and sleep zero; low power unless shutdown one.
// - Mode 10: detection drives enables regardless of shutdown and sleep.
// - Register 0x1f is read-only and always reads zero.
// - Shutdown zero holds lowest power in mode 01 only; one activates and, in modes 01 and 10, starts detection at once.
module hse_regs_top #(
  parameter int unsigned POLL_SLOW_CYC = hse_pkg::POLL_SLOW_CYC_DEF,
  parameter int unsigned POLL_FAST_CYC = hse_pkg::POLL_FAST_CYC_DEF
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic power_down_ctrl,
  input wire logic sleep_ctrl,
  input wire logic det_valid,
  input wire logic det_left,
  input wire logic det_right,
  input wire logic jack_detect_switch_ok,
  input wire logic jack_detect_switch,
  input wire logic [hse_pkg::VOL_W-1:0] vol_target,
  output logic left_channel_on,
  output logic right_channel_on,
  output logic [hse_pkg::VOL_W-1:0] vol_level,
  output logic volume_slew_disable,
  output logic classg_threshold_high,
  output logic poll_req,
  output logic low_power,
  output logic det_start,
  output logic first_enable_ro,
  output logic clock_set_unlocked
);
  import hse_pkg::*;

  logic rst_meta_reg, rst_n_s;
  logic [7:0] en2_reg, en2_next, key_reg;
  logic [1:0] mode;
  logic auto_on, auto_l, auto_r, amp_on, slew_dis, ramp_hold, step_tick;
  logic pdc_prev_reg;
  logic [11:0] slew_cnt_reg;
  logic [VOL_W-1:0] vol_reg, vol_goal;
  logic left_on_reg, right_on_reg;
  logic en2_wr, key_wr;

  hse_regbus_if bus ();

  // Mode codes that hand the enables to the detection logic
  function automatic logic is_auto(input logic [1:0] m);
    is_auto = m == MODE_GATED || m == MODE_FORCED;
  endfunction

  // Reset release through two flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_s <= rst_meta_reg;
    end
  end

  // Serial register access and jack polling
  hse_i2c_slave u_i2c (
    .clock(clock),
    .rst_n(rst_n_s),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe(sda_oe),
    .bus(bus.ctl)
  );

  hse_poll_timer #(
    .SLOW_CYC(POLL_SLOW_CYC),
    .FAST_CYC(POLL_FAST_CYC)
  ) u_poll (
    .clock(clock),
    .rst_n(rst_n_s),
    .fast_sel(en2_reg[EN2_FAST]),
    .switch_ok(jack_detect_switch_ok),
    .switch_closed(jack_detect_switch),
    .poll_req(poll_req)
  );

  // Ownership of the channel enables
  assign mode = en2_reg[EN2_MODE_HI:EN2_MODE_LO];
  assign auto_on = det_valid && (mode == MODE_FORCED ||
    (mode == MODE_GATED && power_down_ctrl && !sleep_ctrl));
  assign auto_l = auto_on & det_left;
  assign auto_r = auto_on & det_right;
  assign en2_wr = bus.wr_stb && bus.addr == ADDR_EN2;
  assign key_wr = bus.wr_stb && bus.addr == ADDR_CLK_KEY;

  // Next value of enable two: host write, then status override
  always_comb begin
    en2_next = en2_reg;
    if (en2_wr) begin
      if (is_auto(bus.wdata[EN2_MODE_HI:EN2_MODE_LO])) begin
        en2_next = {en2_reg[EN2_LEFT:EN2_RIGHT], bus.wdata[EN2_SLEW_DIS:0]};
      end else begin
        en2_next = bus.wdata;
      end
    end
    if (is_auto(en2_next[EN2_MODE_HI:EN2_MODE_LO])) begin
      en2_next[EN2_LEFT] = auto_l;
      en2_next[EN2_RIGHT] = auto_r;
    end
  end

  // Enable two storage; bit 4 is kept as written
  always_ff @(posedge clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      en2_reg <= EN2_RESET;
    end else begin
      en2_reg <= en2_next;
    end
  end

  // Clock unlock key and its decoded state
  always_ff @(posedge clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      key_reg <= CLK_KEY_RESET;
      clock_set_unlocked <= 1'b0;
    end else begin
      if (key_wr) begin
        key_reg <= bus.wdata;
      end
      clock_set_unlocked <= key_reg == CLK_KEY_UNLOCK;
    end
  end

  // Read data; reserved and unmapped offsets read zero
  always_comb begin
    case (bus.addr)
      ADDR_EN2: bus.rdata = en2_reg;
      ADDR_RSVD: bus.rdata = RSVD_VALUE;
      ADDR_CLK_KEY: bus.rdata = key_reg;
      default: bus.rdata = UNMAPPED_VALUE;
    endcase
  end

  // Shutdown control: detection start on activation, low power while held
  always_ff @(posedge clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      pdc_prev_reg <= 1'b0;
      det_start <= 1'b0;
      low_power <= 1'b0;
      first_enable_ro <= 1'b0;
    end else begin
      pdc_prev_reg <= power_down_ctrl;
      det_start <= power_down_ctrl && !pdc_prev_reg && mode != MODE_MANUAL;
      low_power <= mode == MODE_GATED && !power_down_ctrl;
      first_enable_ro <= is_auto(mode);
    end
  end

  // Volume slew step timer
  assign slew_dis = en2_reg[EN2_SLEW_DIS];
  assign step_tick = slew_cnt_reg == SLEW_LAST;
  always_ff @(posedge clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      slew_cnt_reg <= 12'h000;
    end else if (step_tick || slew_dis) begin
      slew_cnt_reg <= 12'h000;
    end else begin
      slew_cnt_reg <= slew_cnt_reg + 12'h001;
    end
  end

  // Volume follows its goal one step per tick, or at once without slewing
  assign amp_on = en2_reg[EN2_LEFT] | en2_reg[EN2_RIGHT];
  assign vol_goal = amp_on ? vol_target : VOL_MIN;
  always_ff @(posedge clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      vol_reg <= VOL_MIN;
    end else if (slew_dis) begin
      vol_reg <= vol_goal;
    end else if (step_tick && vol_reg < vol_goal) begin
      vol_reg <= vol_reg + 6'h01;
    end else if (step_tick && vol_reg > vol_goal) begin
      vol_reg <= vol_reg - 6'h01;
    end
  end

  // Channels stay on until the turn-off ramp reaches minimum
  assign ramp_hold = !amp_on && !slew_dis && vol_reg != VOL_MIN;
  always_ff @(posedge clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      left_on_reg <= 1'b0;
      right_on_reg <= 1'b0;
    end else begin
      left_on_reg <= en2_reg[EN2_LEFT] | (left_on_reg & ramp_hold);
      right_on_reg <= en2_reg[EN2_RIGHT] | (right_on_reg & ramp_hold);
    end
  end

  // Outputs
  assign sda_out = 1'b0;
  assign left_channel_on = left_on_reg;
  assign right_channel_on = right_on_reg;
  assign vol_level = vol_reg;
  assign volume_slew_disable = en2_reg[EN2_SLEW_DIS];
  assign classg_threshold_high = en2_reg[EN2_THR];

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n_s);

  sequence s_gated_down;
    mode == MODE_GATED && !power_down_ctrl;
  endsequence

  sequence s_manual_write;
    en2_wr && !is_auto(bus.wdata[EN2_MODE_HI:EN2_MODE_LO]);
  endsequence

  sequence s_host_write;
    en2_wr;
  endsequence

  sequence s_gated_active;
    mode == MODE_GATED && power_down_ctrl;
  endsequence

  property p_status_follows;
    (is_auto(mode) && !en2_wr) |=> en2_reg[EN2_LEFT:EN2_RIGHT] == $past({auto_l, auto_r});
  endproperty

  status_follow_a: assert property (p_status_follows)
    else $error("channel status does not follow detection in automatic mode");
  manual_write_a: assert property (s_manual_write |=> en2_reg == $past(bus.wdata))
    else $error("manual write not stored");
  ro_ignore_a: assert property (
    (en2_wr && is_auto(mode) && is_auto(bus.wdata[1:0]) && !auto_on) |=> en2_reg[7:6] == 2'b00)
    else $error("read-only channel bits took a host write");
  gated_down_a: assert property (s_gated_down [*3] |-> en2_reg[7:6] == 2'b00 && low_power)
    else $error("gated mode with shutdown low left channels on");
  forced_on_a: assert property ((mode == MODE_FORCED && det_valid && det_left && !en2_wr)
    |=> en2_reg[EN2_LEFT])
    else $error("forced mode did not follow detection");
  slew_bypass_a: assert property (slew_dis |=> vol_reg == $past(vol_goal))
    else $error("volume not immediate with slewing off");
  ramp_step_a: assert property (
    (!$past(slew_dis) && vol_reg != $past(vol_reg)) |->
      (vol_reg == $past(vol_reg) + 6'h01 || vol_reg == $past(vol_reg) - 6'h01))
    else $error("volume jumped more than one step");
  off_hold_a: assert property ((left_on_reg && ramp_hold) |=> left_on_reg)
    else $error("left channel dropped before ramp end");
  det_start_a: assert property (($rose(power_down_ctrl) && mode != MODE_MANUAL) ##1 1'b1
    |-> det_start ##1 !det_start)
    else $error("detection start pulse missing");
  rsvd_read_a: assert property ((bus.addr == ADDR_RSVD) |-> bus.rdata == 8'h00)
    else $error("reserved register read non-zero");
  reset_mode_a: assert property ($rose(rst_n_s) |-> mode == MODE_GATED)
    else $error("mode field reset value wrong");

  // Fields outside the channel pair take every host write
  mode_write_a: assert property (
    s_host_write |=> mode == $past(bus.wdata[EN2_MODE_HI:EN2_MODE_LO]))
    else $error("mode field did not take the host write");
  slew_write_a: assert property (
    s_host_write |=> volume_slew_disable == $past(bus.wdata[EN2_SLEW_DIS]))
    else $error("slew control did not take the host write");
  fast_write_a: assert property (
    s_host_write |=> en2_reg[EN2_FAST] == $past(bus.wdata[EN2_FAST]))
    else $error("polling speed did not take the host write");
  thr_write_a: assert property (
    s_host_write |=> classg_threshold_high == $past(bus.wdata[EN2_THR]))
    else $error("threshold select did not take the host write");
  // Channel outputs follow their register bits one cycle later
  left_follow_a: assert property (en2_reg[EN2_LEFT] |=> left_on_reg)
    else $error("left channel output missed its enable");
  right_follow_a: assert property (en2_reg[EN2_RIGHT] |=> right_on_reg)
    else $error("right channel output missed its enable");
  // Low power only while gated mode has shutdown low
  active_power_a: assert property (s_gated_active |=> !low_power)
    else $error("low power held with shutdown high");
  manual_power_a: assert property ((mode == MODE_MANUAL) |=> !low_power)
    else $error("low power entered in manual mode");
  // Unlock flag reflects the key two cycles after its write
  unlock_flag_a: assert property (
    key_wr ##1 !key_wr |=> clock_set_unlocked == ($past(bus.wdata, 2) == CLK_KEY_UNLOCK))
    else $error("unlock flag does not match the written key");
endmodule
`default_nettype wire

// File: sim/hse_host_model.sv
`default_nettype none
module hse_host_model import hse_pkg::*; (
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus idles with clock driven high; data released, pull-up holds it high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Data changes in the low phase, the line is sampled late in the high phase
  task automatic bit_x(input logic b, output logic r);
    tk(2);
    sda_low <= !b;
    tk(2);
    scl <= 1'b1;
    tk(3);
    r = sda;
    tk(1);
    scl <= 1'b0;
  endtask
  // Start or repeated start: data falls while clock high
  task automatic start();
    tk(2);
    sda_low <= 1'b0;
    tk(2);
    scl <= 1'b1;
    tk(4);
    sda_low <= 1'b1;
    tk(4);
    scl <= 1'b0;
  endtask
  // Stop: data rises while clock high
  task automatic stop();
    tk(2);
    sda_low <= 1'b1;
    tk(2);
    scl <= 1'b1;
    tk(4);
    sda_low <= 1'b0;
    tk(4);
  endtask
  // Eight bits MSB first plus the acknowledge bit
  task automatic byte_x(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
    bit_x(ack_in, ack);
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] x;
    logic k0, k1, k2;
    start();
    byte_x({dev, 1'b0}, 1'b1, x, k0);
    byte_x(a, 1'b1, x, k1);
    byte_x(d, 1'b1, x, k2);
    stop();
    ok = !(k0 | k1 | k2);
  endtask
  // Pointer write, repeated start, one byte read closed by a nack
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] x;
    logic k;
    start();
    byte_x({DEV_ADDR, 1'b0}, 1'b1, x, k);
    byte_x(a, 1'b1, x, k);
    start();
    byte_x({DEV_ADDR, 1'b1}, 1'b1, x, k);
    byte_x(8'hff, 1'b1, d, k);
    stop();
  endtask
endmodule
`default_nettype wire

// File: sim/headset_enable_control_regs_test.sv
`default_nettype none
module headset_enable_control_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import hse_pkg::*;
  localparam int unsigned SLOW = 60;
  localparam int unsigned FAST = 20;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic power_down_ctrl = 1'b0, sleep_ctrl = 1'b0, det_valid = 1'b0, det_left = 1'b0, det_right = 1'b0;
  logic jack_detect_switch_ok = 1'b0, jack_detect_switch = 1'b0;
  logic [VOL_W-1:0] vol_target = 6'h03;
  logic [VOL_W-1:0] vol_level;
  logic scl, sda_low, sda_oe, left_channel_on, right_channel_on, volume_slew_disable;
  logic classg_threshold_high, poll_req, low_power, det_start, first_enable_ro, clock_set_unlocked;
  logic [15:0] cyc = 16'h0000, last = 16'h0000, gap = 16'h0000;
  int fails = 0, checks = 0, npoll = 0, ndet = 0;
  // Open-drain data line with pull-up
  wire logic sda = !(sda_low | sda_oe);
  hse_regs_top #(.POLL_SLOW_CYC(SLOW), .POLL_FAST_CYC(FAST)) u_dut (.clock(clock), .rstn(rstn),
    .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .power_down_ctrl(power_down_ctrl),
    .sleep_ctrl(sleep_ctrl), .det_valid(det_valid), .det_left(det_left), .det_right(det_right),
    .jack_detect_switch_ok(jack_detect_switch_ok), .jack_detect_switch(jack_detect_switch),
    .vol_target(vol_target), .left_channel_on(left_channel_on), .right_channel_on(right_channel_on),
    .vol_level(vol_level), .volume_slew_disable(volume_slew_disable),
    .classg_threshold_high(classg_threshold_high), .poll_req(poll_req), .low_power(low_power),
    .det_start(det_start), .first_enable_ro(first_enable_ro), .clock_set_unlocked(clock_set_unlocked));
  hse_host_model u_host (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));
  always #2.5 clock = ~clock;
  // Pulse bookkeeping and the hang limit
  always @(posedge clock) begin
    cyc <= cyc + 16'h0001;
    if (poll_req === 1'b1) begin
      npoll <= npoll + 1;
      gap <= cyc - last;
      last <= cyc;
    end
    if (det_start === 1'b1) ndet <= ndet + 1;
    if (cyc == 16'd40000) begin
      fails++;
      summarize();
    end
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t byte %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t flag %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(a, d);
    chk_byte(d, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    u_host.wr(DEV_ADDR, a, d, ok);
    chk_bit(ok, 1'b1);
  endtask
  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    logic ok;
    int n;
    tk(3);
    rstn <= 1'b1;
    tk(5);
    chk_bit(first_enable_ro, 1'b1);
    rd_chk(8'h1e, 8'h01);
    rd_chk(8'h1f, 8'h00);
    rd_chk(8'h66, 8'h00);
    wr(8'h1f, 8'hff);
    rd_chk(8'h1f, 8'h00);
    wr(8'h66, 8'hf1);
    chk_bit(clock_set_unlocked, 1'b1);
    rd_chk(8'h66, 8'hf1);
    wr(8'h6f, 8'h01);
    wr(8'h66, 8'h00);
    chk_bit(clock_set_unlocked, 1'b0);
    u_host.wr(7'h15, 8'h1e, 8'h00, ok);
    chk_bit(ok, 1'b0);
    // Forced automatic mode with slewing on; written channel bits are dropped
    wr(8'h1e, 8'hd2);
    rd_chk(8'h1e, 8'h12);
    chk_bit(volume_slew_disable, 1'b0);
    sleep_ctrl <= 1'b1;
    det_valid <= 1'b1;
    det_left <= 1'b1;
    tk(6);
    chk_bit(left_channel_on, 1'b1);
    chk_bit(right_channel_on, 1'b0);
    rd_chk(8'h1e, 8'h92);
    chk_bit(vol_level < 6'h03, 1'b1);
    tk(6500);
    chk_byte({2'b00, vol_level}, 8'h03);
    det_valid <= 1'b0;
    tk(6);
    chk_bit(left_channel_on, 1'b1);
    tk(6500);
    chk_byte({2'b00, vol_level}, 8'h00);
    chk_bit(left_channel_on, 1'b0);
    // Slewing off, high threshold, fast polling without a working switch
    wr(8'h1e, 8'h3e);
    det_valid <= 1'b1;
    det_right <= 1'b1;
    tk(8);
    chk_byte({2'b00, vol_level}, 8'h03);
    chk_bit(volume_slew_disable, 1'b1);
    chk_bit(classg_threshold_high, 1'b1);
    chk_byte(gap[7:0], 8'(FAST));
    wr(8'h1e, 8'h32);
    tk(130);
    chk_byte(gap[7:0], 8'(SLOW));
    chk_bit(classg_threshold_high, 1'b0);
    // Working switch: no polling, insertion seen at once
    jack_detect_switch_ok <= 1'b1;
    tk(200);
    n = npoll;
    tk(200);
    chk_bit(npoll == n, 1'b1);
    jack_detect_switch <= 1'b1;
    tk(5);
    chk_bit(npoll == n + 1, 1'b1);
    // Sleep entry sequence with slewing off so channels drop at once, then gated mode
    wr(8'h1e, 8'h30);
    wr(8'h1e, 8'h31);
    tk(4);
    chk_bit(low_power, 1'b1);
    chk_bit(left_channel_on, 1'b0);
    sleep_ctrl <= 1'b0;
    tk(6);
    chk_bit(right_channel_on, 1'b0);
    n = ndet;
    power_down_ctrl <= 1'b1;
    tk(6);
    chk_bit(ndet == n + 1, 1'b1);
    chk_bit(left_channel_on, 1'b1);
    chk_bit(low_power, 1'b0);
    sleep_ctrl <= 1'b1;
    tk(6);
    chk_bit(right_channel_on, 1'b0);
    // Manual mode after detection finished: software owns the channels
    wr(8'h1e, 8'hf0);
    power_down_ctrl <= 1'b0;
    tk(6);
    chk_bit(left_channel_on, 1'b1);
    chk_bit(right_channel_on, 1'b1);
    chk_bit(low_power, 1'b0);
    chk_bit(first_enable_ro, 1'b0);
    rd_chk(8'h1e, 8'hf0);
    wr(8'h1e, 8'hb0);
    tk(4);
    chk_bit(right_channel_on, 1'b0);
    chk_bit(left_channel_on, 1'b1);
    // Second reset in mid-run
    rstn <= 1'b0;
    tk(3);
    rstn <= 1'b1;
    tk(5);
    chk_bit(left_channel_on, 1'b0);
    rd_chk(8'h1e, 8'h01);
    summarize();
  end
endmodule
`default_nettype wire
